// ---- pkg/a2l_defs.svh ----
// Purpose: Encodings shared by the full-to-lite bus converter
// Assumes: Included by bare name from design and test files
// Notes:   Definitions only
`ifndef A2L_DEFS_SVH
`define A2L_DEFS_SVH

// ----------------------------------------------------------------
// Response codes
// ----------------------------------------------------------------
`define A2L_RESP_OKAY   2'h0
`define A2L_RESP_EXOKAY 2'h1
`define A2L_RESP_SLVERR 2'h2
`define A2L_RESP_DECERR 2'h3

// ----------------------------------------------------------------
// Burst types
// ----------------------------------------------------------------
`define A2L_BURST_FIXED 2'h0
`define A2L_BURST_INCR  2'h1
`define A2L_BURST_WRAP  2'h2

// ----------------------------------------------------------------
// Conversion and protection levels
// ----------------------------------------------------------------
`define A2L_LVL_FULL_CONV   2'h0
`define A2L_LVL_SIMPLE_PROT 2'h1
`define A2L_LVL_FULL_PROT   2'h2

`endif

// ---- pkg/a2l_pkg.sv ----
// Purpose: Types of the full-to-lite bus converter
// Assumes: a2l_defs.svh holds the numeric encodings
// Notes:   Types only
package a2l_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WD   = 4'h1,
    ST_LW   = 4'h2,
    ST_LB   = 4'h3,
    ST_UB   = 4'h4,
    ST_SW   = 4'h5,
    ST_LA   = 4'h6,
    ST_LR   = 4'h7,
    ST_UR   = 4'h8
  } a2l_state_t;

  // ----------------------------------------------------------------
  // Response merger state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsp;
  } a2l_mrg_t;

endpackage

// ---- rtl/a2l_converter.sv ----
// Purpose: Converts full bus transactions into lite single transfers
// Assumes: One transaction in flight; lite slave answers in order
// Notes:   Serialises reads and writes to keep the merge logic simple
// Notes on behaviour
// - Upstream data width not below lite width
// - Bursts split into one transfer per beat
// - Later beats incremented, aligned, wrap at boundary
// - Fixed bursts reuse the start address
// - Split write burst returns one response
// - Any error in split responses is sticky
// - First error code received wins
// - Wide beats split on lite-aligned boundaries
// - Wide beat returns one combined response
// - Narrow transfers forwarded unchanged
// - Write strobes forwarded unmodified
// - Writes with no strobes still forwarded
// - Lock attribute dropped for every transaction
// - Exclusive write always reported as failed
// - Cache attribute dropped, transfers non-bufferable
// - Protection attribute forwarded unchanged
// - Last flags neither forwarded nor expected
// - Protection suppresses out-of-subset transactions with error
// - Simple level suppresses only burst/width cases
// - Full protection suppresses every non-subset transaction
// - Suppressed reads give an error per beat
// - Detection flags out-of-subset access, lets it proceed
// - Responses carry the address-phase transaction ID
// - Lite width fixed at 32 or 64
`timescale 1ns/10ps
`include "a2l_defs.svh"

module a2l_converter
  import a2l_pkg::*;
#(
  parameter int         AW     = 32,
  parameter int         IDW    = 4,
  parameter int         UDW    = 64,
  parameter int         LDW    = 32,
  parameter logic [1:0] LEVEL  = `A2L_LVL_FULL_CONV,
  parameter logic       DETECT = 1'b1
)
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           srst,
  // Upstream write address
  input  wire logic [IDW-1:0] s_awid,
  input  wire logic [AW-1:0]  s_awaddr,
  input  wire logic [7:0]     s_awlen,
  input  wire logic [2:0]     s_awsize,
  input  wire logic [1:0]     s_awburst,
  input  wire logic           s_awlock,
  input  wire logic [3:0]     s_awcache,
  input  wire logic [2:0]     s_awprot,
  input  wire logic           s_awvalid,
  output logic                s_awready,
  // Upstream write data and response
  input  wire logic [UDW-1:0] s_wdata,
  input  wire logic [UDW/8-1:0] s_wstrb,
  input  wire logic           s_wvalid,
  output logic                s_wready,
  output logic [IDW-1:0]      s_bid,
  output logic [1:0]          s_bresp,
  output logic                s_bvalid,
  input  wire logic           s_bready,
  // Upstream read address
  input  wire logic [IDW-1:0] s_arid,
  input  wire logic [AW-1:0]  s_araddr,
  input  wire logic [7:0]     s_arlen,
  input  wire logic [2:0]     s_arsize,
  input  wire logic [1:0]     s_arburst,
  input  wire logic           s_arlock,
  input  wire logic [3:0]     s_arcache,
  input  wire logic [2:0]     s_arprot,
  input  wire logic           s_arvalid,
  output logic                s_arready,
  // Upstream read data
  output logic [IDW-1:0]      s_rid,
  output logic [UDW-1:0]      s_rdata,
  output logic [1:0]          s_rresp,
  output logic                s_rlast,
  output logic                s_rvalid,
  input  wire logic           s_rready,
  // Lite write side
  output logic [AW-1:0]       m_awaddr,
  output logic [2:0]          m_awprot,
  output logic                m_awvalid,
  input  wire logic           m_awready,
  output logic [LDW-1:0]      m_wdata,
  output logic [LDW/8-1:0]    m_wstrb,
  output logic                m_wvalid,
  input  wire logic           m_wready,
  input  wire logic [1:0]     m_bresp,
  input  wire logic           m_bvalid,
  output logic                m_bready,
  // Lite read side
  output logic [AW-1:0]       m_araddr,
  output logic [2:0]          m_arprot,
  output logic                m_arvalid,
  input  wire logic           m_arready,
  input  wire logic [LDW-1:0] m_rdata,
  input  wire logic [1:0]     m_rresp,
  input  wire logic           m_rvalid,
  output logic                m_rready,
  // Detection status
  input  wire logic           det_clr,
  output logic                det_flag
);

  localparam int         UB  = UDW / 8;
  localparam int         LB  = LDW / 8;
  localparam logic [2:0] LSZ = 3'($clog2(LB));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    a2l_state_t     st;
    logic           tog;
    logic           awr;
    logic           arr;
    logic           wr;
    logic           bv;
    logic           rv;
    logic           rl;
    logic           mawv;
    logic           mwv;
    logic           marv;
    logic           mbr;
    logic           mrr;
    logic           sup;
    logic           det;
    logic [IDW-1:0] id;
    logic [AW-1:0]  a0;
    logic [AW-1:0]  a;
    logic [AW-1:0]  pa;
    logic [7:0]     len;
    logic [7:0]     beat;
    logic [2:0]     size;
    logic [1:0]     burst;
    logic [2:0]     prot;
    logic [UDW-1:0] wd;
    logic [UB-1:0]  ws;
    logic [LDW-1:0] lwd;
    logic [LB-1:0]  lws;
    logic [UDW-1:0] rbuf;
  } a2l_core_t;

  a2l_core_t  q;
  a2l_core_t  d;
  logic       wclr, wupd, rclr, rupd;
  logic [1:0] wrsp, rrsp;

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  function automatic logic [AW-1:0] align(input logic [AW-1:0] ad,
                                          input logic [2:0]    sz);
    align = ad & ~((AW'(1) << sz) - AW'(1));
  endfunction

  function automatic logic [AW-1:0] nbeat(input logic [AW-1:0] ad,
                                          input logic [2:0]    sz,
                                          input logic [7:0]    ln,
                                          input logic [1:0]    bt);
    logic [AW-1:0] inc;
    logic [AW-1:0] wsz;
    inc = align(ad, sz) + (AW'(1) << sz);
    wsz = (AW'(ln) + AW'(1)) << sz;
    case (bt)
      `A2L_BURST_FIXED: nbeat = ad;
      `A2L_BURST_WRAP:  nbeat = (ad & ~(wsz - AW'(1)))
                                | (inc & (wsz - AW'(1)));
      default:          nbeat = inc;
    endcase
  endfunction

  // Bit offset of the lite lane that holds an address
  function automatic logic [AW-1:0] lsh(input logic [AW-1:0] ad);
    lsh = ((ad & AW'(UB - 1)) >> LSZ) * AW'(LDW);
  endfunction

  function automatic logic [AW-1:0] ssh(input logic [AW-1:0] ad);
    ssh = ((ad & AW'(UB - 1)) >> LSZ) * AW'(LB);
  endfunction

  // Last lite piece of the current beat
  function automatic logic lastp(input a2l_core_t s);
    lastp = (s.size <= LSZ) || (align(s.pa, LSZ) + AW'(LB)
            >= align(s.a, s.size) + (AW'(1) << s.size));
  endfunction

  // Out-of-subset check and suppression decision
  function automatic logic [1:0] classify(input logic [7:0] ln,
                                          input logic [2:0] sz,
                                          input logic       lk,
                                          input logic [3:0] ch);
    logic cplx;
    logic nc;
    cplx = (ln != 8'h00) || (sz != LSZ);
    nc   = cplx || lk || (ch != 4'h0);
    case (LEVEL)
      `A2L_LVL_SIMPLE_PROT: classify = {cplx, nc};
      `A2L_LVL_FULL_PROT:   classify = {nc, nc};
      default:              classify = {1'b0, nc};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [1:0] cl;
    logic       dset;
    cl   = 2'h0;
    dset = 1'b0;
    d    = q;
    wclr = 1'b0;
    wupd = 1'b0;
    wrsp = `A2L_RESP_SLVERR;
    rclr = 1'b0;
    rupd = 1'b0;
    rrsp = `A2L_RESP_SLVERR;
    case (q.st)
      ST_IDLE:
      begin
        d.tog = !q.tog;
        // Lock and cache only feed the check, never the lite side
        if (s_awvalid && q.awr)
        begin
          cl      = classify(s_awlen, s_awsize, s_awlock, s_awcache);
          dset    = cl[0];
          d.sup   = cl[1];
          d.id    = s_awid;
          d.a0    = s_awaddr;
          d.a     = s_awaddr;
          d.len   = s_awlen;
          d.size  = s_awsize;
          d.burst = s_awburst;
          d.prot  = s_awprot;
          d.beat  = 8'h00;
          wclr    = 1'b1;
          wupd    = cl[1];
          d.st    = cl[1] ? ST_SW : ST_WD;
        end
        else if (s_arvalid && q.arr)
        begin
          cl      = classify(s_arlen, s_arsize, s_arlock, s_arcache);
          dset    = cl[0];
          d.sup   = cl[1];
          d.id    = s_arid;
          d.a0    = s_araddr;
          d.a     = s_araddr;
          d.pa    = s_araddr;
          d.len   = s_arlen;
          d.size  = s_arsize;
          d.burst = s_arburst;
          d.prot  = s_arprot;
          d.beat  = 8'h00;
          d.rbuf  = '0;
          rclr    = 1'b1;
          rupd    = cl[1];
          d.rv    = cl[1];
          d.rl    = (s_arlen == 8'h00);
          d.marv  = !cl[1];
          d.st    = cl[1] ? ST_UR : ST_LA;
        end
      end
      ST_WD:
      begin
        if (s_wvalid && q.wr)
        begin
          d.wd   = s_wdata;
          d.ws   = s_wstrb;
          d.pa   = q.a;
          d.lwd  = LDW'(s_wdata >> lsh(q.a));
          d.lws  = LB'(s_wstrb >> ssh(q.a));
          d.mawv = 1'b1;
          d.mwv  = 1'b1;
          d.st   = ST_LW;
        end
      end
      ST_LW:
      begin
        if (m_awready && q.mawv)
          d.mawv = 1'b0;
        if (m_wready && q.mwv)
          d.mwv = 1'b0;
        if (!d.mawv && !d.mwv)
        begin
          d.mbr = 1'b1;
          d.st  = ST_LB;
        end
      end
      ST_LB:
      begin
        if (m_bvalid && q.mbr)
        begin
          wupd  = 1'b1;
          wrsp  = m_bresp;
          d.mbr = 1'b0;
          if (!lastp(q))
          begin
            d.pa   = align(q.pa, LSZ) + AW'(LB);
            d.lwd  = LDW'(q.wd >> lsh(d.pa));
            d.lws  = LB'(q.ws >> ssh(d.pa));
            d.mawv = 1'b1;
            d.mwv  = 1'b1;
            d.st   = ST_LW;
          end
          else if (q.beat == q.len)
          begin
            d.bv = 1'b1;
            d.st = ST_UB;
          end
          else
          begin
            d.a    = nbeat(q.a, q.size, q.len, q.burst);
            d.beat = q.beat + 8'h01;
            d.st   = ST_WD;
          end
        end
      end
      ST_SW:
      begin
        // Beats are counted, so the last flag is not needed
        if (s_wvalid && q.wr)
        begin
          d.beat = q.beat + 8'h01;
          if (q.beat == q.len)
          begin
            d.bv = 1'b1;
            d.st = ST_UB;
          end
        end
      end
      ST_UB:
      begin
        if (s_bready && q.bv)
        begin
          d.bv = 1'b0;
          d.st = ST_IDLE;
        end
      end
      ST_LA:
      begin
        if (m_arready && q.marv)
        begin
          d.marv = 1'b0;
          d.mrr  = 1'b1;
          d.st   = ST_LR;
        end
      end
      ST_LR:
      begin
        if (m_rvalid && q.mrr)
        begin
          d.mrr  = 1'b0;
          rupd   = 1'b1;
          rrsp   = m_rresp;
          d.rbuf = (q.rbuf & ~(UDW'({LDW{1'b1}}) << lsh(q.pa)))
                   | (UDW'(m_rdata) << lsh(q.pa));
          if (!lastp(q))
          begin
            d.pa   = align(q.pa, LSZ) + AW'(LB);
            d.marv = 1'b1;
            d.st   = ST_LA;
          end
          else
          begin
            d.rv = 1'b1;
            d.rl = (q.beat == q.len);
            d.st = ST_UR;
          end
        end
      end
      ST_UR:
      begin
        if (s_rready && q.rv)
        begin
          d.rv = 1'b0;
          if (q.beat == q.len)
            d.st = ST_IDLE;
          else
          begin
            d.beat = q.beat + 8'h01;
            d.rbuf = '0;
            rclr   = 1'b1;
            rupd   = q.sup;
            d.rv   = q.sup;
            d.rl   = (q.beat + 8'h01 == q.len);
            d.a    = nbeat(q.a, q.size, q.len, q.burst);
            d.pa   = d.a;
            d.marv = !q.sup;
            d.st   = q.sup ? ST_UR : ST_LA;
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Ready alternates so one address is taken per cycle
    d.awr = (d.st == ST_IDLE) && !d.tog;
    d.arr = (d.st == ST_IDLE) && d.tog;
    d.wr  = (d.st == ST_WD) || (d.st == ST_SW);
    d.det = (DETECT && dset) || (q.det && !det_clr);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Response mergers
  // ----------------------------------------------------------------
  a2l_resp_merge u_wmerge (
    .mclk   (mclk),
    .srst   (srst),
    .clr    (wclr),
    .upd    (wupd),
    .rsp    (wrsp),
    .merged (s_bresp)
  );

  a2l_resp_merge u_rmerge (
    .mclk   (mclk),
    .srst   (srst),
    .clr    (rclr),
    .upd    (rupd),
    .rsp    (rrsp),
    .merged (s_rresp)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_awready = q.awr;
  assign s_arready = q.arr;
  assign s_wready  = q.wr;
  assign s_bvalid  = q.bv;
  assign s_bid     = q.id;
  assign s_rid     = q.id;
  assign s_rdata   = q.rbuf;
  assign s_rlast   = q.rl;
  assign s_rvalid  = q.rv;
  assign m_awaddr  = q.pa;
  assign m_araddr  = q.pa;
  assign m_awprot  = q.prot;
  assign m_arprot  = q.prot;
  assign m_awvalid = q.mawv;
  assign m_wvalid  = q.mwv;
  assign m_wdata   = q.lwd;
  assign m_wstrb   = q.lws;
  assign m_bready  = q.mbr;
  assign m_arvalid = q.marv;
  assign m_rready  = q.mrr;
  assign det_flag  = q.det;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic err_seen_q;
  always_ff @(posedge mclk)
  begin
    if (srst || q.st == ST_IDLE)
      err_seen_q <= 1'b0;
    else if (m_bvalid && q.mbr && m_bresp[1])
      err_seen_q <= 1'b1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_width_cfg: assert property (
    UDW >= LDW && (LDW == 32 || LDW == 64))
    else $error("unsupported data widths");
  a_sup_blocked: assert property (
    q.sup && q.st != ST_IDLE |-> !m_awvalid && !m_arvalid)
    else $error("suppressed access reached lite side");
  a_fixed_addr: assert property (
    m_arvalid && q.burst == `A2L_BURST_FIXED && q.size <= LSZ
    |-> m_araddr == q.a0)
    else $error("fixed burst address moved");
  a_sticky_b: assert property (
    s_bvalid && err_seen_q |-> s_bresp[1])
    else $error("error lost in merged write response");
  a_one_bresp: assert property (
    s_bvalid && s_bready |=> !s_bvalid [*2])
    else $error("extra write response");
  a_sup_rlast: assert property (
    s_rvalid && q.sup |-> s_rresp == `A2L_RESP_SLVERR
                          && s_rlast == (q.beat == q.len))
    else $error("bad suppressed read beat");
  a_strb_pass: assert property (
    $rose(m_wvalid) |-> m_wstrb == LB'(q.ws >> ssh(q.pa)))
    else $error("lite strobes altered");
  a_det_sticky: assert property (
    det_flag && !det_clr |=> det_flag)
    else $error("detection flag lost");
  a_id_reflect: assert property (
    s_awvalid && s_awready |=> s_bid == $past(s_awid))
    else $error("write id not reflected");

  c_sup_read: cover property (s_rvalid && s_rready && s_rlast && q.sup);
  c_split_wr: cover property (s_bvalid && q.len != 8'h00 && !q.sup);
  c_wide_rd:  cover property (s_rvalid && q.size > LSZ && !q.sup);
  c_detect:   cover property ($rose(det_flag));

endmodule // a2l_converter

// ---- rtl/a2l_resp_merge.sv ----
// Purpose: Merges split responses into one combined response
// Assumes: clr and upd are same-clock strobes
// Notes:   clr and upd in one cycle load rsp onto a clean slate
`timescale 1ns/10ps
`include "a2l_defs.svh"

module a2l_resp_merge
  import a2l_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Control
  input  wire logic       clr,
  input  wire logic       upd,
  input  wire logic [1:0] rsp,
  // Result
  output logic      [1:0] merged
);

  a2l_mrg_t   q;
  a2l_mrg_t   d;
  logic [1:0] base;

  always_comb
  begin
    d    = q;
    base = clr ? `A2L_RESP_OKAY : q.rsp;
    d.rsp = base;
    if (upd && !base[1])
    begin
      // Once an error is held, later codes are ignored
      d.rsp = rsp[1] ? rsp : `A2L_RESP_OKAY;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  assign merged = q.rsp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_merge_hold: assert property (
    q.rsp[1] && !clr |=> merged == $past(merged))
    else $error("held error code changed");
  a_no_exokay: assert property (
    merged != `A2L_RESP_EXOKAY)
    else $error("exclusive okay reported");

endmodule // a2l_resp_merge

// ---- test/a2l_converter_test.sv ----
// Purpose: Self-checking bench of the full-to-lite converter
// Assumes: Default parameters, lite model on the far side
// Notes:   Expected addresses and responses derived here
`timescale 1ns/10ps
`include "a2l_defs.svh"
module a2l_converter_test;
  logic        mclk = 0, srst = 1, slow = 0, det_clr = 0, det_flag;
  logic [3:0]  s_awid, s_arid, s_bid, s_rid, s_awcache, s_arcache, m_wstrb;
  logic [31:0] s_awaddr, s_araddr, m_awaddr, m_araddr, m_wdata, m_rdata;
  logic [7:0]  s_awlen, s_arlen, s_wstrb;
  logic [2:0]  s_awsize, s_arsize, s_awprot, s_arprot, m_awprot, m_arprot;
  logic [1:0]  s_awburst, s_arburst, s_bresp, s_rresp, m_bresp, m_rresp;
  logic [63:0] s_wdata, s_rdata;
  logic        s_awlock, s_arlock, s_awvalid, s_awready, s_wvalid, s_wready,
               s_bvalid, s_bready, s_arvalid, s_arready, s_rlast, s_rvalid,
               s_rready, m_awvalid, m_awready, m_wvalid, m_wready, m_bvalid,
               m_bready, m_arvalid, m_arready, m_rvalid, m_rready;
  int          errors = 0, tests_run = 0, seed = 30966, k;

  a2l_converter  u_a2l_converter  (.*);
  a2l_lite_slave u_a2l_lite_slave (.*);

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] ers(logic [31:0] a);
    return (a[3:2] == 2'h1) ? 2'h0 : a[3:2];
  endfunction

  function automatic logic [31:0] nxt(logic [31:0] a, logic [2:0] sz,
                                      logic [7:0] ln, logic [1:0] bt);
    logic [31:0] n, m;
    n = ((a >> sz) << sz) + (32'h1 << sz);
    m = ((32'(ln) + 32'h1) << sz) - 32'h1;
    if (bt == `A2L_BURST_FIXED) return a;
    if (bt == `A2L_BURST_WRAP) return (a & ~m) | (n & m);
    return n;
  endfunction

  function automatic logic rdy(int w);
    case (w)
      0: return s_awready;
      1: return s_wready;
      2: return s_bvalid;
      3: return s_arready;
      default: return s_rvalid;
    endcase
  endfunction

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait; the edge after it completes the handshake
  task automatic wt(int w);
    for (int n = 0; rdy(w) !== 1'b1; n++)
    begin
      if (n > 200)
      begin
        errors++;
        wrap_up();
      end
      @(posedge mclk) #1;
    end
  endtask

  task automatic wr(logic [31:0] a, logic [7:0] ln, logic [2:0] sz,
                    logic [1:0] bt, logic lk, logic [3:0] ch);
    logic [1:0]  ex;
    logic [31:0] ad, pc, ed;
    logic [3:0]  es;
    int          n, cnt;
    ex  = `A2L_RESP_OKAY;
    ad  = a;
    cnt = 0;
    n   = u_a2l_lite_slave.n_wr;
    {s_awaddr, s_awlen, s_awsize, s_awburst, s_awlock} = {a, ln, sz, bt, lk};
    {s_awid, s_awcache, s_awprot} = {4'($random(seed)), ch, 3'($random(seed))};
    s_awvalid = 1;
    wt(0);
    @(posedge mclk) #1;
    s_awvalid = 0;
    s_wvalid  = 1;
    for (int b = 0; b <= ln; b++)
    begin
      s_wdata = {$random(seed), $random(seed)};
      // Odd beats carry no strobes at all
      s_wstrb = b[0] ? 8'h00 : 8'($random(seed));
      for (int p = 0; p < ((sz == 3) ? 2 : 1); p++)
      begin
        pc = ad + 32'(4 * p);
        if (ex == `A2L_RESP_OKAY) ex = ers(pc);
        ed = pc[2] ? s_wdata[63:32] : s_wdata[31:0];
        es = pc[2] ? s_wstrb[7:4] : s_wstrb[3:0];
        cnt++;
      end
      ad = nxt(ad, sz, ln, bt);
      wt(1);
      @(posedge mclk) #1;
    end
    s_wvalid = 0;
    wt(2);
    chk(s_bresp, ex);
    chk(s_bid, s_awid);
    chk(u_a2l_lite_slave.n_wr - n, cnt);
    chk(u_a2l_lite_slave.la, pc);
    chk(u_a2l_lite_slave.ld, ed);
    chk(u_a2l_lite_slave.ls, es);
    chk(u_a2l_lite_slave.lp, s_awprot);
    @(posedge mclk) #1;
  endtask

  task automatic rd(logic [31:0] a, logic [7:0] ln, logic [2:0] sz,
                    logic [1:0] bt);
    logic [31:0] ad, f, g;
    ad = a;
    {s_araddr, s_arlen, s_arsize, s_arburst, s_arlock} = {a, ln, sz, bt, 1'b0};
    {s_arid, s_arcache, s_arprot} = {4'($random(seed)), 4'h0,
                                     3'($random(seed))};
    s_arvalid = 1;
    wt(3);
    @(posedge mclk) #1;
    s_arvalid = 0;
    for (int b = 0; b <= ln; b++)
    begin
      wt(4);
      f = {ad[15:0], ~ad[15:0]};
      g = ad + 32'h4;
      // Wide beats gather both lite words, lower lane first
      chk(s_rdata, (sz == 3) ? {g[15:0], ~g[15:0], f} :
                   (ad[2] ? {f, 32'h0} : {32'h0, f}));
      chk(m_arprot, s_arprot);
      chk(s_rresp, ers(ad));
      chk(s_rlast, b == ln);
      chk(s_rid, s_arid);
      @(posedge mclk) #1;
      ad = nxt(ad, sz, ln, bt);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {s_awvalid, s_wvalid, s_arvalid, s_awlock, s_arlock} = 5'h00;
    {s_awid, s_awaddr, s_awlen, s_awsize, s_awburst, s_awcache} = 0;
    {s_arid, s_araddr, s_arlen, s_arsize, s_arburst, s_arcache} = 0;
    {s_wdata, s_wstrb, s_awprot, s_arprot} = 0;
    {s_bready, s_rready} = 2'h3;
    repeat (10) @(posedge mclk);
    #1 srst = 0;
    wr(32'h00, 0, 2, `A2L_BURST_INCR, 0, 4'h0);
    chk(det_flag, 0);
    wr(32'h00, 0, 2, `A2L_BURST_INCR, 1, 4'hF);
    chk(det_flag, 1);
    det_clr = 1;
    @(posedge mclk) #1;
    det_clr = 0;
    chk(det_flag, 0);
    $display("test detect done");
    wr(32'h22, 2, 2, `A2L_BURST_INCR, 0, 4'h0);
    wr(32'h0C, 1, 2, `A2L_BURST_INCR, 0, 4'h0);
    wr(32'h08, 0, 3, `A2L_BURST_INCR, 0, 4'h0);
    wr(32'h10, 1, 3, `A2L_BURST_INCR, 0, 4'h3);
    wr(32'h30, 3, 2, `A2L_BURST_FIXED, 0, 4'h0);
    wr(32'h3C, 3, 2, `A2L_BURST_WRAP, 0, 4'h0);
    wr(32'h06, 0, 1, `A2L_BURST_INCR, 0, 4'h0);
    $display("test write split done");
    rd(32'h108, 3, 2, `A2L_BURST_WRAP);
    rd(32'h04, 2, 2, `A2L_BURST_FIXED);
    rd(32'h06, 0, 1, `A2L_BURST_INCR);
    rd(32'h0C, 1, 2, `A2L_BURST_INCR);
    rd(32'h10, 1, 3, `A2L_BURST_INCR);
    $display("test read split done");
    for (k = 0; k < 24; k++)
    begin
      slow = 1'($random(seed));
      wr(32'($random(seed)) & 32'hFFC, 8'($random(seed) & 3), 2,
         2'($random(seed) & 1), 0, 4'($random(seed)));
      rd(32'($random(seed)) & 32'hFFC, 8'($random(seed) & 3), 2,
         2'($random(seed) & 1));
    end
    $display("test random done");
    wrap_up();
  end
endmodule // a2l_converter_test

// ---- test/a2l_lite_slave.sv ----
// Purpose: Lite slave model facing the converter
// Assumes: Response code follows address bits 3:2
// Notes:   slow withholds ready on alternate cycles
`timescale 1ns/10ps
module a2l_lite_slave
(
  // Clock, reset and pacing
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        slow,
  // Write side
  input  wire logic [31:0] m_awaddr,
  input  wire logic [2:0]  m_awprot,
  input  wire logic        m_awvalid,
  output logic             m_awready,
  input  wire logic [31:0] m_wdata,
  input  wire logic [3:0]  m_wstrb,
  input  wire logic        m_wvalid,
  output logic             m_wready,
  output logic [1:0]       m_bresp,
  output logic             m_bvalid,
  input  wire logic        m_bready,
  // Read side
  input  wire logic [31:0] m_araddr,
  input  wire logic        m_arvalid,
  output logic             m_arready,
  output logic [31:0]      m_rdata,
  output logic [1:0]       m_rresp,
  output logic             m_rvalid,
  input  wire logic        m_rready
);
  logic        ga, gw, tk, bv, rv;
  logic [31:0] la, ld, rd;
  logic [3:0]  ls;
  logic [2:0]  lp;
  logic [1:0]  br, rr;
  int          n_wr;

  // Never answers the exclusive-okay code
  function automatic logic [1:0] ers(logic [31:0] a);
    return (a[3:2] == 2'h1) ? 2'h0 : a[3:2];
  endfunction

  assign m_awready = !ga && (!slow || tk);
  assign m_wready  = !gw && (!slow || tk);
  assign m_arready = !rv && (!slow || tk);
  assign m_bvalid  = bv;
  assign m_rvalid  = rv;
  // Idle outputs show the inverse so a stale value never looks fresh
  assign m_bresp   = bv ? br : ~br;
  assign m_rresp   = rv ? rr : ~rr;
  assign m_rdata   = rv ? rd : ~rd;

  always @(posedge mclk)
  begin
    if (srst)
    begin
      {ga, gw, tk, bv, rv} <= 5'h00;
      n_wr <= 0;
    end
    else
    begin
      tk <= !tk;
      if (bv && m_bready) bv <= 1'b0;
      if (rv && m_rready) rv <= 1'b0;
      if (m_awvalid && m_awready) {ga, la, lp} <= {1'b1, m_awaddr, m_awprot};
      if (m_wvalid && m_wready) {gw, ld, ls} <= {1'b1, m_wdata, m_wstrb};
      if (ga && gw)
      begin
        {ga, gw, bv} <= 3'h1;
        br   <= ers(la);
        n_wr <= n_wr + 1;
      end
      if (m_arvalid && m_arready)
        {rv, rd, rr} <= {1'b1, m_araddr[15:0], ~m_araddr[15:0],
                         ers(m_araddr)};
    end
  end
endmodule // a2l_lite_slave
